// >>> rtl/irct_pkg.sv
package irct_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_NARROW_CTRL = 6'h00;
  localparam logic [5:0] IDX_COMMON = 6'h01;
  localparam logic [5:0] IDX_WIDE_CTRL = 6'h02;
  localparam logic [5:0] IDX_NRELOAD_LOW = 6'h04;
  localparam logic [5:0] IDX_NRELOAD_HIGH = 6'h05;
  localparam logic [5:0] IDX_WRELOAD_LOW = 6'h06;
  localparam logic [5:0] IDX_WRELOAD_HIGH = 6'h07;
  localparam logic [5:0] IDX_WCAP_LOW = 6'h08;
  localparam logic [5:0] IDX_WCAP_HIGH = 6'h09;
  localparam logic [5:0] IDX_NCAP_LOW = 6'h0a;
  localparam logic [5:0] IDX_NCAP_HIGH = 6'h0b;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
  localparam int ADDR_IDX_LO = 2;
  localparam int ADDR_IDX_HI = 7;

  // ==========================================================
  // common control fields
  localparam int BIT_MODE = 7;
  localparam int BIT_SELECT = 6;
  localparam int FLD_LOGIC_HI = 5;
  localparam int FLD_LOGIC_LO = 4;

  // ==========================================================
  // counter control fields (same layout for both counters)
  localparam int BIT_ENABLE = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int FLD_CLK_HI = 4;
  localparam int FLD_CLK_LO = 3;
  localparam int BIT_CAP_IE = 2;
  localparam int BIT_TO_IE = 1;
  localparam int BIT_ROUTE = 0;

  // ==========================================================
  // codes
  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_NOR = 2'h2;
  localparam logic [1:0] LOGIC_NAND = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] CLK_DIV1 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV4 = 2'h2;
  localparam logic [1:0] CLK_DIV8 = 2'h3;

  // ==========================================================
  // reset and load values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] COMMON_KEEP_MASK = 8'h30;
  localparam logic [7:0] WIDE_KEEP_MASK = 8'h1c;
  localparam logic [7:0] NARROW_KEEP_MASK = 8'h00;
  localparam logic [7:0] NARROW_LOAD = 8'hff;
  localparam logic [15:0] WIDE_LOAD = 16'hffff;

  // ==========================================================
  // interrupt status bits
  localparam int ST_WCAP = 0;
  localparam int ST_WTO = 1;
  localparam int ST_NCAP = 2;
  localparam int ST_NTO = 3;
  localparam int ST_W = 4;

endpackage

// >>> rtl/irct_top.sv
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps

module irct_top (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // power management
  input wire logic stop_recovery,
  // plain port data for the shared pins
  input wire logic port_wide_data,
  input wire logic port_narrow_data,
  input wire logic port_combined_data,
  // signal pins
  input wire logic default_demod_input_pin,
  input wire logic alt_demod_input_pin,
  output logic wide_output_pin,
  output logic narrow_output_pin,
  output logic combined_output_pin,
  // interrupt
  output logic irq
);

  // ==========================================================
  // functions
  function automatic logic tick_of(input logic [1:0] sel, input logic [2:0] div);
    logic t;
    t = 1'b0;
    unique case (sel)
      irct_pkg::CLK_DIV1: t = 1'b1;
      irct_pkg::CLK_DIV2: t = div[0];
      irct_pkg::CLK_DIV4: t = &div[1:0];
      irct_pkg::CLK_DIV8: t = &div;
    endcase
    return t;
  endfunction

  function automatic logic qual_edge(input logic [1:0] code, input logic rise, input logic fall);
    logic q;
    case (code)
      irct_pkg::EDGE_FALL: q = fall;
      irct_pkg::EDGE_RISE: q = rise;
      irct_pkg::EDGE_BOTH: q = rise | fall;
      default: q = 1'b0;
    endcase
    return q;
  endfunction

  // ==========================================================
  // declarations
  logic [7:0] common_reg, wide_ctrl_reg, narrow_ctrl_reg;
  logic [7:0] nreload_low_reg, nreload_high_reg, wreload_low_reg, wreload_high_reg;
  logic [7:0] wcap_low_reg, wcap_high_reg, ncap_low_reg, ncap_high_reg;
  logic [15:0] wide_cnt_reg;
  logic [7:0] narrow_cnt_reg;
  logic wide_en_reg, narrow_en_reg, wide_to_reg, narrow_to_reg;
  logic wide_out_reg, narrow_out_reg, wide_armed_reg;
  logic [irct_pkg::ST_W-1:0] status_reg, mask_reg, status_set, irq_enables;
  logic [2:0] div_reg;
  logic def_meta_reg, def_sync_reg, alt_meta_reg, alt_sync_reg, demod_prev_reg;
  logic wr_pend_reg;
  logic [5:0] wr_idx_reg;
  logic [31:0] hrdata_reg, rdata_next;
  logic irq_reg, wide_pin_reg, narrow_pin_reg, comb_pin_reg;
  logic addr_phase, rd_status, demod, demod_in, rise, fall, qual;
  logic wide_wr, narrow_wr, wide_tick, narrow_tick, wide_edge;
  logic wide_live, narrow_live, wide_cap_ev, wide_tc_ev, narrow_cap_ev, narrow_tc_ev;
  logic combined;
  logic [5:0] a_idx;
  logic [7:0] wd;
  logic [15:0] wide_reload;
  logic [7:0] narrow_reload;

  // ==========================================================
  // bus slave
  assign a_idx = haddr[irct_pkg::ADDR_IDX_HI:irct_pkg::ADDR_IDX_LO];
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_status = addr_phase & !hwrite & (a_idx == irct_pkg::IDX_IRQ_STATUS);
  assign wd = hwdata[7:0];
  assign wide_wr = wr_pend_reg & (wr_idx_reg == irct_pkg::IDX_WIDE_CTRL);
  assign narrow_wr = wr_pend_reg & (wr_idx_reg == irct_pkg::IDX_NARROW_CTRL);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 6'h00;
      hrdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        wr_idx_reg <= a_idx;
      if (addr_phase && !hwrite)
        hrdata_reg <= rdata_next;
    end
  end

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    unique case (a_idx)
      irct_pkg::IDX_COMMON: rdata_next[7:0] = common_reg;
      irct_pkg::IDX_WIDE_CTRL: rdata_next[7:0] = {wide_en_reg, wide_ctrl_reg[6], wide_to_reg, wide_ctrl_reg[4:0]};
      irct_pkg::IDX_NARROW_CTRL: rdata_next[7:0] = {narrow_en_reg, narrow_ctrl_reg[6], narrow_to_reg,
                                                    narrow_ctrl_reg[4:0]};
      irct_pkg::IDX_NRELOAD_LOW: rdata_next[7:0] = nreload_low_reg;
      irct_pkg::IDX_NRELOAD_HIGH: rdata_next[7:0] = nreload_high_reg;
      irct_pkg::IDX_WRELOAD_LOW: rdata_next[7:0] = wreload_low_reg;
      irct_pkg::IDX_WRELOAD_HIGH: rdata_next[7:0] = wreload_high_reg;
      irct_pkg::IDX_WCAP_LOW: rdata_next[7:0] = wcap_low_reg;
      irct_pkg::IDX_WCAP_HIGH: rdata_next[7:0] = wcap_high_reg;
      irct_pkg::IDX_NCAP_LOW: rdata_next[7:0] = ncap_low_reg;
      irct_pkg::IDX_NCAP_HIGH: rdata_next[7:0] = ncap_high_reg;
      irct_pkg::IDX_IRQ_STATUS: rdata_next[irct_pkg::ST_W-1:0] = status_reg;
      irct_pkg::IDX_IRQ_MASK: rdata_next[irct_pkg::ST_W-1:0] = mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // control registers; kept fields survive stop-mode recovery
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      common_reg <= irct_pkg::REG_RST;
      wide_ctrl_reg <= irct_pkg::REG_RST;
      narrow_ctrl_reg <= irct_pkg::REG_RST;
      nreload_low_reg <= irct_pkg::REG_RST;
      nreload_high_reg <= irct_pkg::REG_RST;
      wreload_low_reg <= irct_pkg::REG_RST;
      wreload_high_reg <= irct_pkg::REG_RST;
      mask_reg <= '0;
    end
    else if (stop_recovery)
    begin
      common_reg <= common_reg & irct_pkg::COMMON_KEEP_MASK;
      wide_ctrl_reg <= wide_ctrl_reg & irct_pkg::WIDE_KEEP_MASK;
      narrow_ctrl_reg <= narrow_ctrl_reg & irct_pkg::NARROW_KEEP_MASK;
    end
    else if (wr_pend_reg)
    begin
      unique case (wr_idx_reg)
        irct_pkg::IDX_COMMON: common_reg <= wd;
        irct_pkg::IDX_WIDE_CTRL: wide_ctrl_reg <= wd;
        irct_pkg::IDX_NARROW_CTRL: narrow_ctrl_reg <= wd;
        irct_pkg::IDX_NRELOAD_LOW: nreload_low_reg <= wd;
        irct_pkg::IDX_NRELOAD_HIGH: nreload_high_reg <= wd;
        irct_pkg::IDX_WRELOAD_LOW: wreload_low_reg <= wd;
        irct_pkg::IDX_WRELOAD_HIGH: wreload_high_reg <= wd;
        irct_pkg::IDX_IRQ_MASK: mask_reg <= wd[irct_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // prescaler and demodulator input
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 3'h0;
    else
      div_reg <= div_reg + 3'h1;
  end

  assign wide_tick = tick_of(wide_ctrl_reg[irct_pkg::FLD_CLK_HI:irct_pkg::FLD_CLK_LO], div_reg);
  assign narrow_tick = tick_of(narrow_ctrl_reg[irct_pkg::FLD_CLK_HI:irct_pkg::FLD_CLK_LO], div_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      def_meta_reg <= 1'b0;
      def_sync_reg <= 1'b0;
      alt_meta_reg <= 1'b0;
      alt_sync_reg <= 1'b0;
      demod_prev_reg <= 1'b0;
    end
    else
    begin
      def_meta_reg <= default_demod_input_pin;
      def_sync_reg <= def_meta_reg;
      alt_meta_reg <= alt_demod_input_pin;
      alt_sync_reg <= alt_meta_reg;
      demod_prev_reg <= demod_in;
    end
  end

  assign demod = common_reg[irct_pkg::BIT_MODE];
  assign demod_in = common_reg[irct_pkg::BIT_SELECT] ? alt_sync_reg : def_sync_reg;
  assign rise = demod_in & !demod_prev_reg;
  assign fall = !demod_in & demod_prev_reg;
  assign qual = qual_edge(common_reg[irct_pkg::FLD_LOGIC_HI:irct_pkg::FLD_LOGIC_LO], rise, fall);

  // ==========================================================
  // wide counter
  assign wide_reload = {wreload_high_reg, wreload_low_reg};
  assign wide_edge = qual & (!wide_ctrl_reg[irct_pkg::BIT_SINGLE] | wide_armed_reg);
  assign wide_live = wide_en_reg & !wide_wr & !stop_recovery;
  assign wide_cap_ev = wide_live & demod & wide_edge;
  assign wide_tc_ev = wide_live & !wide_cap_ev & wide_tick & (wide_cnt_reg == 16'h0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wide_en_reg <= 1'b0;
      wide_cnt_reg <= 16'h0000;
      wide_out_reg <= 1'b0;
      wide_armed_reg <= 1'b1;
      wcap_low_reg <= irct_pkg::REG_RST;
      wcap_high_reg <= irct_pkg::REG_RST;
    end
    else if (stop_recovery)
    begin
      wide_en_reg <= 1'b0;
      wide_out_reg <= 1'b0;
    end
    else if (wide_wr)
    begin
      wide_en_reg <= wd[irct_pkg::BIT_ENABLE];
      wide_armed_reg <= 1'b1;
      if (wd[irct_pkg::BIT_ENABLE] && !wide_en_reg)
        wide_cnt_reg <= demod ? irct_pkg::WIDE_LOAD : wide_reload;
    end
    else if (wide_cap_ev)
    begin
      wcap_low_reg <= wide_cnt_reg[7:0];
      wcap_high_reg <= wide_cnt_reg[15:8];
      wide_cnt_reg <= irct_pkg::WIDE_LOAD;
      wide_armed_reg <= 1'b0;
    end
    else if (wide_live && wide_tick)
    begin
      if (wide_cnt_reg != 16'h0000)
        wide_cnt_reg <= wide_cnt_reg - 16'h0001;
      else if (demod)
        wide_cnt_reg <= irct_pkg::WIDE_LOAD;
      else
      begin
        wide_out_reg <= !wide_out_reg;
        if (wide_ctrl_reg[irct_pkg::BIT_SINGLE])
          wide_en_reg <= 1'b0;
        else
          wide_cnt_reg <= wide_reload;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wide_to_reg <= 1'b0;
    else if (stop_recovery)
      wide_to_reg <= 1'b0;
    else if (wide_tc_ev)
      wide_to_reg <= 1'b1;
    else if (wide_wr && wd[irct_pkg::BIT_TIMEOUT])
      wide_to_reg <= 1'b0;
  end

  // ==========================================================
  // narrow counter; transmit alternates high and low reload by output level
  assign narrow_reload = narrow_out_reg ? nreload_low_reg : nreload_high_reg;
  assign narrow_live = narrow_en_reg & !narrow_wr & !stop_recovery;
  assign narrow_cap_ev = narrow_live & demod & qual;
  assign narrow_tc_ev = narrow_live & !narrow_cap_ev & narrow_tick & (narrow_cnt_reg == 8'h00);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      narrow_en_reg <= 1'b0;
      narrow_cnt_reg <= 8'h00;
      narrow_out_reg <= 1'b0;
      ncap_low_reg <= irct_pkg::REG_RST;
      ncap_high_reg <= irct_pkg::REG_RST;
    end
    else if (stop_recovery)
    begin
      narrow_en_reg <= 1'b0;
      narrow_out_reg <= 1'b0;
    end
    else if (narrow_wr)
    begin
      narrow_en_reg <= wd[irct_pkg::BIT_ENABLE];
      if (wd[irct_pkg::BIT_ENABLE] && !narrow_en_reg)
        narrow_cnt_reg <= demod ? irct_pkg::NARROW_LOAD : (narrow_out_reg ? nreload_high_reg : nreload_low_reg);
    end
    else if (narrow_cap_ev)
    begin
      if (rise)
        ncap_low_reg <= narrow_cnt_reg;
      else
        ncap_high_reg <= narrow_cnt_reg;
      narrow_cnt_reg <= irct_pkg::NARROW_LOAD;
    end
    else if (narrow_live && narrow_tick)
    begin
      if (narrow_cnt_reg != 8'h00)
        narrow_cnt_reg <= narrow_cnt_reg - 8'h01;
      else if (demod)
        narrow_cnt_reg <= irct_pkg::NARROW_LOAD;
      else
      begin
        narrow_out_reg <= !narrow_out_reg;
        if (narrow_ctrl_reg[irct_pkg::BIT_SINGLE])
          narrow_en_reg <= 1'b0;
        else
          narrow_cnt_reg <= narrow_reload;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      narrow_to_reg <= 1'b0;
    else if (stop_recovery)
      narrow_to_reg <= 1'b0;
    else if (narrow_tc_ev)
      narrow_to_reg <= 1'b1;
    else if (narrow_wr && wd[irct_pkg::BIT_TIMEOUT])
      narrow_to_reg <= 1'b0;
  end

  // ==========================================================
  // interrupts: sticky status, cleared by a read, set wins
  assign status_set = {narrow_tc_ev, narrow_cap_ev, wide_tc_ev, wide_cap_ev};
  assign irq_enables = {narrow_ctrl_reg[irct_pkg::BIT_TO_IE], narrow_ctrl_reg[irct_pkg::BIT_CAP_IE],
                        wide_ctrl_reg[irct_pkg::BIT_TO_IE], wide_ctrl_reg[irct_pkg::BIT_CAP_IE]};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_reg <= '0;
    else
      status_reg <= (rd_status ? '0 : status_reg) | status_set;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(status_reg & mask_reg & irq_enables);
  end

  // ==========================================================
  // pins
  always_comb
  begin
    combined = 1'b0;
    unique case (common_reg[irct_pkg::FLD_LOGIC_HI:irct_pkg::FLD_LOGIC_LO])
      irct_pkg::LOGIC_AND: combined = narrow_out_reg & wide_out_reg;
      irct_pkg::LOGIC_OR: combined = narrow_out_reg | wide_out_reg;
      irct_pkg::LOGIC_NOR: combined = !(narrow_out_reg | wide_out_reg);
      irct_pkg::LOGIC_NAND: combined = !(narrow_out_reg & wide_out_reg);
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wide_pin_reg <= 1'b0;
      narrow_pin_reg <= 1'b0;
      comb_pin_reg <= 1'b0;
    end
    else
    begin
      wide_pin_reg <= wide_ctrl_reg[irct_pkg::BIT_ROUTE] ? wide_out_reg : port_wide_data;
      narrow_pin_reg <= narrow_ctrl_reg[irct_pkg::BIT_ROUTE] ? narrow_out_reg : port_narrow_data;
      comb_pin_reg <= (!demod && common_reg[irct_pkg::BIT_SELECT]) ? combined : port_combined_data;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_reg;
  assign wide_output_pin = wide_pin_reg;
  assign narrow_output_pin = narrow_pin_reg;
  assign combined_output_pin = comb_pin_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_mode_pin;
    !demod && common_reg[irct_pkg::BIT_SELECT] |=> combined_output_pin == $past(combined);
  endproperty
  a_mode_pin: assert property (p_mode_pin) else $error("combined pin not driven by logic");

  property p_demod_sel;
    demod && common_reg[irct_pkg::BIT_SELECT] |-> demod_in == alt_sync_reg;
  endproperty
  a_demod_sel: assert property (p_demod_sel) else $error("alt input not selected");

  property p_enable_write;
    wide_wr && !stop_recovery |=> wide_en_reg == $past(wd[irct_pkg::BIT_ENABLE]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write not taken");

  property p_modulo;
    wide_tc_ev && !demod && !wide_ctrl_reg[irct_pkg::BIT_SINGLE] |=> wide_cnt_reg == $past(wide_reload) && wide_en_reg;
  endproperty
  a_modulo: assert property (p_modulo) else $error("modulo reload failed");

  property p_single;
    wide_tc_ev && !demod && wide_ctrl_reg[irct_pkg::BIT_SINGLE] |=> !wide_en_reg;
  endproperty
  a_single: assert property (p_single) else $error("single pass did not stop");

  property p_capture;
    wide_cap_ev |=> {wcap_high_reg, wcap_low_reg} == $past(wide_cnt_reg) && wide_cnt_reg == irct_pkg::WIDE_LOAD;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_ignore;
    wide_en_reg && wide_ctrl_reg[irct_pkg::BIT_SINGLE] && !wide_armed_reg |-> !wide_cap_ev;
  endproperty
  a_ignore: assert property (p_ignore) else $error("edge taken after first");

  property p_timeout_set;
    wide_tc_ev |=> wide_to_reg [*2];
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("timeout flag not set");

  property p_timeout_keep;
    wide_to_reg && !stop_recovery && !(wide_wr && wd[irct_pkg::BIT_TIMEOUT]) |=> wide_to_reg;
  endproperty
  a_timeout_keep: assert property (p_timeout_keep) else $error("timeout flag lost");

  property p_div8;
    wide_en_reg && wide_ctrl_reg[irct_pkg::FLD_CLK_HI:irct_pkg::FLD_CLK_LO] == irct_pkg::CLK_DIV8 && wide_tick
      |=> (!wide_tick || wide_ctrl_reg[irct_pkg::FLD_CLK_HI:irct_pkg::FLD_CLK_LO] != irct_pkg::CLK_DIV8) [*7];
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight wrong");

  property p_irq_gate;
    !wide_ctrl_reg[irct_pkg::BIT_CAP_IE] && !wide_ctrl_reg[irct_pkg::BIT_TO_IE] && !narrow_ctrl_reg[irct_pkg::BIT_CAP_IE]
      && !narrow_ctrl_reg[irct_pkg::BIT_TO_IE] |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt with enables clear");

  property p_route;
    wide_ctrl_reg[irct_pkg::BIT_ROUTE] |=> wide_output_pin == $past(wide_out_reg);
  endproperty
  a_route: assert property (p_route) else $error("wide pin not routed");

  c_modulo: cover property (wide_tc_ev && !demod ##1 wide_en_reg);
  c_capture: cover property (wide_cap_ev);
  c_irq: cover property (irq);

endmodule

// >>> sim/irct_ir_source.sv
`timescale 1ns/1ps
// ==========
// ir signal source: the chosen pin carries the signal, the other toggles as noise
module irct_ir_source (
  // clock
  input wire logic hclk,
  // control from the bench
  input wire logic sel,
  input wire logic lvl,
  // signal pins
  output logic default_demod_input_pin,
  output logic alt_demod_input_pin
);
  logic noise_reg = 1'b0;
  always @(posedge hclk)
  begin
    noise_reg <= ~noise_reg;
  end
  assign default_demod_input_pin = sel ? noise_reg : lvl;
  assign alt_demod_input_pin = sel ? lvl : noise_reg;
endmodule

// >>> sim/irct_tb.sv
`timescale 1ns/1ps
// ==========
// bench: bus tasks, reference values and scenarios
module ir_counter_timer_control_tb_top;
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stop_recovery = 1'b0;
  logic pw = 1'b0, pn = 1'b0, pc = 1'b0, sel = 1'b0, lvl = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, wpin, npin, cpin, irq, d0, d1;
  int fail_count = 0;
  int check_count = 0;
  int n;
  int mdl [int];
  irct_top irct_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .stop_recovery(stop_recovery), .port_wide_data(pw),
    .port_narrow_data(pn), .port_combined_data(pc), .default_demod_input_pin(d0),
    .alt_demod_input_pin(d1), .wide_output_pin(wpin), .narrow_output_pin(npin),
    .combined_output_pin(cpin), .irq(irq));
  irct_ir_source irct_ir_source_i (.hclk(hclk), .sel(sel), .lvl(lvl),
    .default_demod_input_pin(d0), .alt_demod_input_pin(d1));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task rdy;
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 20)
      begin
        fail_count++;
        results;
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
    if (w)
      mdl[a] = d;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task wirq;
    n = 0;
    while (irq !== 1'b1)
    begin
      @(posedge hclk);
      #1;
      n++;
      if (n > 2000)
      begin
        fail_count++;
        results;
      end
    end
  endtask
  initial
  begin
    void'($urandom(32'hf76b8b8c));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rc(8'h04, 32'h0000_0000);
    rc(8'h08, 32'h0000_0000);
    rc(8'h30, 32'h0000_0000);
    repeat (4)
    begin
      @(posedge hclk);
      {pw, pn, pc} <= 3'($urandom);
      @(posedge hclk);
      #1;
      chk(32'({wpin, npin, cpin}), 32'({pw, pn, pc}));
    end
    bus(1'b1, 8'h04, {24'h00_0000, 8'($urandom)});
    rc(8'h04, mdl[8'h04]);
    // both counter outputs idle at 0 while disabled
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'h04, {24'h00_0000, 2'h1, c[1:0], 4'h0});
      repeat (2) @(posedge hclk);
      #1;
      chk(32'(cpin), 32'(c[1]));
    end
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0004);
    bus(1'b1, 8'h44, 32'h0000_0002);
    for (int d = 0; d < 4; d++)
    begin
      bus(1'b1, 8'h08, 32'h0000_0083 | (d << 3));
      wirq;
      chk(32'(n >= (4 << d) && n <= (6 << d) + 6), 32'h0000_0001);
      rc(8'h08, 32'h0000_00a3 | (d << 3));
      bus(1'b1, 8'h08, 32'h0000_0003 | (d << 3));
      rc(8'h08, 32'h0000_0023 | (d << 3));
      bus(1'b1, 8'h08, 32'h0000_0020);
      rc(8'h08, 32'h0000_0000);
      rc(8'h40, 32'h0000_0002);
      rc(8'h40, 32'h0000_0000);
    end
    bus(1'b1, 8'h08, 32'h0000_00c3);
    wirq;
    rc(8'h08, 32'h0000_0063);
    bus(1'b1, 8'h08, 32'h0000_0020);
    bus(1'b0, 8'h40, 32'h0000_0000);
    bus(1'b1, 8'h44, 32'h0000_0001);
    // demodulation: code 0 captures falling edges, 1 rising, 2 both, 3 none; 4 is single capture on both edges
    for (int c = 0; c < 5; c++)
    begin
      sel <= c[0];
      bus(1'b1, 8'h04, (c == 4) ? 32'h0000_00a0 : {24'h00_0000, 1'b1, c[0], c[1:0], 4'h0});
      repeat (6) @(posedge hclk);
      bus(1'b1, 8'h08, (c == 4) ? 32'h0000_00c4 : 32'h0000_0084);
      bus(1'b1, 8'h00, 32'h0000_0080);
      bus(1'b0, 8'h40, 32'h0000_0000);
      for (int e = 1; e >= 0; e--)
      begin
        lvl <= e[0];
        repeat (6) @(posedge hclk);
        #1;
        chk(32'(irq), 32'((c == 4) ? (e == 1) : (c == 2 || c == e)));
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'((c == 4) ? (e == 1) : (c == 2 || c == e)));
        chk(32'((rd & 32'h0000_0004) != 0), 32'(c == 2 || c == 4 || c == e));
      end
      rc(8'h24, 32'h0000_00ff);
      bus(1'b1, 8'h08, 32'h0000_0000);
      bus(1'b1, 8'h00, 32'h0000_0000);
    end
    // narrow counter: transmit single pass from reload low 2
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h10, 32'h0000_0002);
    bus(1'b1, 8'h14, 32'h0000_0003);
    bus(1'b1, 8'h44, 32'h0000_0008);
    bus(1'b1, 8'h00, 32'h0000_00c3);
    wirq;
    chk(32'(n), 32'h0000_0004);
    chk(32'(npin), 32'h0000_0001);
    rc(8'h00, 32'h0000_0063);
    rc(8'h40, 32'h0000_0008);
    bus(1'b1, 8'h04, 32'h0000_00f0);
    bus(1'b1, 8'h08, 32'h0000_005d);
    @(posedge hclk);
    stop_recovery <= 1'b1;
    @(posedge hclk);
    stop_recovery <= 1'b0;
    rc(8'h04, 32'h0000_0030);
    rc(8'h08, 32'h0000_001c);
    rc(8'h44, mdl[8'h44]);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(8'h04, 32'h0000_0000);
    rc(8'h08, 32'h0000_0000);
    results;
  end
endmodule
